// File: rtl/spm_pkg.sv
// Shared constants and types of the servo panel mode and status monitor
package spm_pkg;
  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] SPM_OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] SPM_OFS_INPUT_MASK = 8'h04;
  localparam logic [7:0] SPM_OFS_JOG_SPEED = 8'h08;
  localparam logic [7:0] SPM_OFS_STATUS = 8'h0C;
  localparam logic [7:0] SPM_OFS_PANEL = 8'h10;
  localparam logic [7:0] SPM_OFS_DISPLAY = 8'h14;
  localparam logic [7:0] SPM_OFS_HIST_DATA = 8'h18;
  localparam logic [7:0] SPM_OFS_HIST_IDX = 8'h1C;
  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] SPM_FUNC_SEL_RST = 8'h00;
  localparam logic [15:0] SPM_INPUT_MASK_RST = 16'h0000;
  localparam logic [15:0] SPM_JOG_SPEED_RST = 16'h0000;
  localparam int SPM_MASK_SERVO_ON_BIT = 0;
  localparam int SPM_MASK_TRAVEL_BIT = 1;
  // ****************************************
  // Function select codes
  // ****************************************
  localparam logic [7:0] SPM_FN_JOG = 8'h00;
  localparam logic [7:0] SPM_FN_CLR_HIST = 8'h02;
  localparam logic [7:0] SPM_FN_MOTOR_PRM = 8'h04;
  localparam logic [7:0] SPM_FN_VERSION = 8'h06;
  // ****************************************
  // Status word layout
  // ****************************************
  localparam int SPM_STAT_W = 21;
  localparam int SPM_ST_ALARM = 1;
  localparam int SPM_ST_DBRAKE = 2;
  localparam int SPM_ST_CLT = 4;
  localparam int SPM_ST_POSITIONING_COMPLETE = 5;
  localparam int SPM_ST_MSW = 6;
  localparam int SPM_ST_FCL = 7;
  localparam int SPM_ST_RCL = 8;
  localparam int SPM_ST_MOTOR = 9;
  localparam int SPM_ST_PA = 10;
  localparam int SPM_ST_PU = 13;
  localparam int SPM_ST_SERVO_ENERGIZED_STATE = 16;
  localparam int SPM_ST_PCON = 17;
  localparam int SPM_ST_FOT = 18;
  localparam int SPM_ST_ROT = 19;
  // ****************************************
  // Monitor and history
  // ****************************************
  localparam logic [2:0] SPM_MON_COUNT = 3'd6;
  localparam logic [2:0] SPM_MON_STATUS = 3'd4;
  localparam int SPM_HIST_DEPTH = 10;
  localparam int SPM_HIST_IW = 4;
  localparam int SPM_CODE_W = 8;
  typedef enum logic [2:0] {
    SPM_NUM_SEL, SPM_VAL_SHOW, SPM_FUNC_RUN, SPM_MON_SEL, SPM_MON_VAL,
    SPM_TRACE, SPM_STATUS_DISP
  } spm_state_t;
endpackage : spm_pkg

// File: rtl/spm_hist_if.sv
// Carrier between panel logic and alarm history memory
interface spm_hist_if;
  import spm_pkg::*;
  logic wr_en;
  logic [SPM_CODE_W-1:0] wr_code;
  logic clr;
  logic [SPM_HIST_IW-1:0] rd_idx;
  logic [SPM_CODE_W-1:0] rd_data;
  modport mem (input wr_en, wr_code, clr, rd_idx, output rd_data);
  modport ctl (output wr_en, wr_code, clr, rd_idx, input rd_data);
endinterface : spm_hist_if

// File: rtl/spm_hist_mem.sv
// Alarm history memory, newest entry at index zero
module spm_hist_mem #(
  parameter int DEPTH = spm_pkg::SPM_HIST_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  spm_hist_if.mem hb
);
  import spm_pkg::*;
  logic [SPM_CODE_W-1:0] ent [DEPTH];
  logic [DEPTH-1:0] valid;
  // ****************************************
  // Storage: a new alarm beats a clear in the same cycle
  // ****************************************
  always_ff @(posedge mclk) begin
    if (hb.wr_en) begin
      ent[0] <= hb.wr_code;
      for (int i = 1; i < DEPTH; i++) begin
        ent[i] <= ent[i-1];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      valid <= '0;
    end else if (hb.wr_en) begin
      valid <= hb.clr ? {{(DEPTH-1){1'b0}}, 1'b1} : {valid[DEPTH-2:0], 1'b1};
    end else if (hb.clr) begin
      valid <= '0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hb.rd_data <= '0;
    end else if (32'(hb.rd_idx) < DEPTH && valid[hb.rd_idx]) begin
      hb.rd_data <= ent[hb.rd_idx];
    end else begin
      hb.rd_data <= '0;
    end
  end
endmodule : spm_hist_mem

// File: rtl/spm_panel.sv
// Servo panel mode sequencer, status monitor and AHB-Lite register slave
// Functional notes
// - Function select 00 selects jog operation.
// - In jog setting, display key toggles operation mode on and off.
// - In operation mode, jog key toggles servo energized state.
// - Up key held runs reverse at second jog speed.
// - Down key held runs forward, stops on release.
// - Select 02: display key clears alarm history, shows select value.
// - Select 04: display key shows motor type and modification index.
// - Select 06: display key shows firmware version.
// - Data key returns to number selection; display key enters monitor.
// - Monitor offers speed, torque, pulses, angle, status word, error.
// - Up/down pick monitor, data toggles value, display goes traceback.
// - Bit 1 servo alarm, bit 2 dynamic brake, bit 3 unused.
// - Bit 4 current limit, bit 5 positioned, bit 6 mode switch.
// - Bits 7, 8 current limits, bit 9 motor energized.
// - Bits 10-12 show encoder A, B, C inverted.
// - Bits 13-15 show hall U, V, W inverted, incremental only.
// - Bits 16-19 servo on, P control, forward, reverse inhibit.
module spm_panel #(
  parameter logic [23:0] FW_VERSION = 24'h00_0001 // Value is arbitrary
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic display_mode_key,
  input wire logic jog_servo_toggle_key,
  input wire logic data_enter_key,
  input wire logic up_key,
  input wire logic down_key,
  input wire logic servo_alarm_flag,
  input wire logic dynamic_brake_active,
  input wire logic current_limit_active,
  input wire logic positioning_complete,
  input wire logic mode_switch_active,
  input wire logic forward_current_limit,
  input wire logic reverse_current_limit,
  input wire logic motor_energized,
  input wire logic encoder_phase_a_level,
  input wire logic encoder_quadrature_b_level,
  input wire logic encoder_index_level,
  input wire logic hall_u_level,
  input wire logic hall_v_level,
  input wire logic hall_w_level,
  input wire logic incremental_encoder,
  input wire logic ext_servo_on,
  input wire logic proportional_control_input,
  input wire logic forward_travel_inhibit,
  input wire logic reverse_travel_inhibit,
  input wire logic [15:0] feedback_speed,
  input wire logic [15:0] torque_ref,
  input wire logic [15:0] pulse_count,
  input wire logic [15:0] elec_angle,
  input wire logic [15:0] position_error,
  input wire logic [7:0] motor_type,
  input wire logic [7:0] motor_mod_index,
  input wire logic alarm_event,
  input wire logic [7:0] alarm_code,
  output logic servo_energized_state,
  output logic servo_command,
  output logic operation_mode,
  output logic jog_fwd,
  output logic jog_rev,
  output logic [15:0] jog_speed,
  output logic [2:0] panel_state,
  output logic [23:0] display_value
);
  import spm_pkg::*;

  spm_hist_if hb ();
  spm_hist_mem #(.DEPTH(SPM_HIST_DEPTH)) u_hist (
    .mclk(mclk),
    .reset_n(reset_n),
    .hb(hb)
  );

  spm_state_t state;
  logic [7:0] panel_function_select;
  logic [15:0] input_mask_config;
  logic [15:0] second_jog_speed;
  logic [SPM_STAT_W-1:0] internal_status_monitor;
  logic [7:0] const_num;
  logic [2:0] mon_num;
  logic [SPM_HIST_IW-1:0] trace_idx;
  logic [1:0] shown_func;
  logic prev_disp, prev_jog, prev_data, prev_up, prev_down;
  logic disp_press, jog_press, data_press, up_press, down_press;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_fsel_wr;
  logic hist_clr;
  logic fwd_block, rev_block;

  // ****************************************
  // Key press detection
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev_disp <= 1'b0;
      prev_jog <= 1'b0;
      prev_data <= 1'b0;
      prev_up <= 1'b0;
      prev_down <= 1'b0;
    end else begin
      prev_disp <= display_mode_key;
      prev_jog <= jog_servo_toggle_key;
      prev_data <= data_enter_key;
      prev_up <= up_key;
      prev_down <= down_key;
    end
  end
  assign disp_press = display_mode_key & ~prev_disp;
  assign jog_press = jog_servo_toggle_key & ~prev_jog;
  assign data_press = data_enter_key & ~prev_data;
  assign up_press = up_key & ~prev_up;
  assign down_press = down_key & ~prev_down;

  // ****************************************
  // Panel mode sequencer
  // ****************************************
  assign hist_clr = (state == SPM_VAL_SHOW) && disp_press &&
                    (const_num == 8'h00) &&
                    (panel_function_select == SPM_FN_CLR_HIST);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= SPM_NUM_SEL;
      shown_func <= 2'd0;
    end else begin
      case (state)
        SPM_NUM_SEL: begin
          if (data_press) begin
            state <= SPM_VAL_SHOW;
          end else if (disp_press) begin
            state <= SPM_MON_SEL;
          end
        end
        SPM_VAL_SHOW: begin
          if (data_press) begin
            state <= SPM_NUM_SEL;
          end else if (disp_press && const_num == 8'h00) begin
            case (panel_function_select)
              SPM_FN_JOG: begin
                state <= SPM_FUNC_RUN;
                shown_func <= 2'd0;
              end
              SPM_FN_MOTOR_PRM: begin
                state <= SPM_FUNC_RUN;
                shown_func <= 2'd1;
              end
              SPM_FN_VERSION: begin
                state <= SPM_FUNC_RUN;
                shown_func <= 2'd2;
              end
              default: state <= SPM_VAL_SHOW;
            endcase
          end else if (disp_press) begin
            state <= SPM_MON_SEL;
          end
        end
        SPM_FUNC_RUN: begin
          if (data_press) begin
            state <= SPM_NUM_SEL;
          end else if (disp_press) begin
            state <= SPM_VAL_SHOW;
          end
        end
        SPM_MON_SEL: begin
          if (data_press) begin
            state <= SPM_MON_VAL;
          end else if (disp_press) begin
            state <= SPM_TRACE;
          end
        end
        SPM_MON_VAL: begin
          if (data_press) begin
            state <= SPM_MON_SEL;
          end else if (disp_press) begin
            state <= SPM_TRACE;
          end
        end
        SPM_TRACE: begin
          if (disp_press) begin
            state <= SPM_STATUS_DISP;
          end
        end
        SPM_STATUS_DISP: begin
          if (disp_press) begin
            state <= SPM_NUM_SEL;
          end
        end
        default: state <= SPM_NUM_SEL;
      endcase
    end
  end

  // ****************************************
  // Selection counters
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      const_num <= 8'h00;
    end else if (state == SPM_NUM_SEL && up_press) begin
      const_num <= const_num + 8'h01;
    end else if (state == SPM_NUM_SEL && down_press) begin
      const_num <= const_num - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mon_num <= 3'd0;
    end else if (state == SPM_MON_SEL && up_press) begin
      mon_num <= (mon_num == SPM_MON_COUNT - 3'd1) ? 3'd0
                 : mon_num + 3'd1;
    end else if (state == SPM_MON_SEL && down_press) begin
      mon_num <= (mon_num == 3'd0) ? SPM_MON_COUNT - 3'd1
                 : mon_num - 3'd1;
    end
  end

  // Key scrolling beats a bus write
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      trace_idx <= '0;
    end else if (state == SPM_TRACE && up_press) begin
      trace_idx <= (32'(trace_idx) == SPM_HIST_DEPTH - 1) ? '0
                   : trace_idx + 1'b1;
    end else if (state == SPM_TRACE && down_press) begin
      trace_idx <= (trace_idx == '0) ? SPM_HIST_IW'(SPM_HIST_DEPTH - 1)
                   : trace_idx - 1'b1;
    end else if (wr_pend && wr_addr == SPM_OFS_HIST_IDX) begin
      trace_idx <= hwdata[SPM_HIST_IW-1:0];
    end
  end

  // ****************************************
  // Operation mode and jog
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      operation_mode <= 1'b0;
    end else begin
      operation_mode <= (state == SPM_FUNC_RUN) &&
                        (shown_func == 2'd0);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      servo_energized_state <= 1'b0;
    end else if (!operation_mode || state != SPM_FUNC_RUN) begin
      servo_energized_state <= 1'b0;
    end else if (jog_press) begin
      servo_energized_state <= ~servo_energized_state;
    end
  end

  // Unmasked unwired inputs would hold the servo or block jog
  assign fwd_block = forward_travel_inhibit &
                     ~input_mask_config[SPM_MASK_TRAVEL_BIT];
  assign rev_block = reverse_travel_inhibit &
                     ~input_mask_config[SPM_MASK_TRAVEL_BIT];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      servo_command <= 1'b0;
      jog_fwd <= 1'b0;
      jog_rev <= 1'b0;
      jog_speed <= SPM_JOG_SPEED_RST;
    end else begin
      servo_command <= servo_energized_state | (ext_servo_on &
                       ~input_mask_config[SPM_MASK_SERVO_ON_BIT]);
      jog_rev <= operation_mode & servo_energized_state & up_key &
                 ~down_key & ~rev_block;
      jog_fwd <= operation_mode & servo_energized_state & down_key &
                 ~up_key & ~fwd_block;
      jog_speed <= second_jog_speed;
    end
  end

  // ****************************************
  // Internal status word
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      internal_status_monitor <= '0;
    end else begin
      internal_status_monitor <= '0;
      internal_status_monitor[SPM_ST_ALARM] <= servo_alarm_flag;
      internal_status_monitor[SPM_ST_DBRAKE] <= dynamic_brake_active;
      internal_status_monitor[SPM_ST_CLT] <= current_limit_active;
      internal_status_monitor[SPM_ST_POSITIONING_COMPLETE] <= positioning_complete;
      internal_status_monitor[SPM_ST_MSW] <= mode_switch_active;
      internal_status_monitor[SPM_ST_FCL] <= forward_current_limit;
      internal_status_monitor[SPM_ST_RCL] <= reverse_current_limit;
      internal_status_monitor[SPM_ST_MOTOR] <= motor_energized;
      internal_status_monitor[SPM_ST_PA +: 3] <= ~{encoder_index_level,
        encoder_quadrature_b_level, encoder_phase_a_level};
      internal_status_monitor[SPM_ST_PU +: 3] <= {3{incremental_encoder}} &
        ~{hall_w_level, hall_v_level, hall_u_level};
      internal_status_monitor[SPM_ST_SERVO_ENERGIZED_STATE] <= servo_command;
      internal_status_monitor[SPM_ST_PCON] <= proportional_control_input;
      internal_status_monitor[SPM_ST_FOT] <= forward_travel_inhibit;
      internal_status_monitor[SPM_ST_ROT] <= reverse_travel_inhibit;
    end
  end

  // ****************************************
  // Display
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      display_value <= 24'h00_0000;
      panel_state <= 3'd0;
    end else begin
      panel_state <= state;
      case (state)
        SPM_NUM_SEL: display_value <= 24'(const_num);
        SPM_VAL_SHOW: display_value <= (const_num == 8'h00) ?
          24'(panel_function_select) : '0;
        SPM_FUNC_RUN: begin
          case (shown_func)
            2'd1: display_value <= {8'h00, motor_type,
                                    motor_mod_index};
            2'd2: display_value <= FW_VERSION;
            default: display_value <= 24'(servo_energized_state);
          endcase
        end
        SPM_MON_SEL: display_value <= 24'(mon_num);
        SPM_MON_VAL: begin
          case (mon_num)
            3'd0: display_value <= 24'(feedback_speed);
            3'd1: display_value <= 24'(torque_ref);
            3'd2: display_value <= 24'(pulse_count);
            3'd3: display_value <= 24'(elec_angle);
            SPM_MON_STATUS: display_value <=
              24'(internal_status_monitor);
            default: display_value <= 24'(position_error);
          endcase
        end
        SPM_TRACE: display_value <= {12'h000, trace_idx, hb.rd_data};
        SPM_STATUS_DISP: display_value <= 24'(internal_status_monitor);
        default: display_value <= 24'h00_0000;
      endcase
    end
  end

  // ****************************************
  // Alarm history port
  // ****************************************
  assign hb.wr_en = alarm_event;
  assign hb.wr_code = alarm_code;
  assign hb.clr = hist_clr;
  assign hb.rd_idx = trace_idx;

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_addr <= haddr[7:0];
    end
  end
  assign bus_fsel_wr = wr_pend && wr_addr == SPM_OFS_FUNC_SEL;

  // Panel keys only edit the select value while it is shown
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      panel_function_select <= SPM_FUNC_SEL_RST;
    end else if (bus_fsel_wr) begin
      panel_function_select <= hwdata[7:0];
    end else if (state == SPM_VAL_SHOW && const_num == 8'h00 && up_press) begin
      panel_function_select <= panel_function_select + 8'h01;
    end else if (state == SPM_VAL_SHOW && const_num == 8'h00 &&
                 down_press) begin
      panel_function_select <= panel_function_select - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      input_mask_config <= SPM_INPUT_MASK_RST;
      second_jog_speed <= SPM_JOG_SPEED_RST;
    end else if (wr_pend) begin
      if (wr_addr == SPM_OFS_INPUT_MASK) begin
        input_mask_config <= hwdata[15:0];
      end
      if (wr_addr == SPM_OFS_JOG_SPEED) begin
        second_jog_speed <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        SPM_OFS_FUNC_SEL: hrdata <= 32'(panel_function_select);
        SPM_OFS_INPUT_MASK: hrdata <= 32'(input_mask_config);
        SPM_OFS_JOG_SPEED: hrdata <= 32'(second_jog_speed);
        SPM_OFS_STATUS: hrdata <= 32'(internal_status_monitor);
        SPM_OFS_PANEL: hrdata <= {20'h0_0000, mon_num, 2'b00,
          servo_energized_state, operation_mode, 2'b00, state};
        SPM_OFS_DISPLAY: hrdata <= 32'(display_value);
        SPM_OFS_HIST_DATA: hrdata <= 32'(hb.rd_data);
        SPM_OFS_HIST_IDX: hrdata <= 32'(trace_idx);
        default: hrdata <= '0;
      endcase
    end
  end
endmodule : spm_panel

// File: tb/spm_panel_asserts.sv
// Port-level assertions for the panel sequencer
module spm_panel_checker (
  input logic mclk,
  input logic reset_n,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input logic display_mode_key,
  input logic jog_servo_toggle_key,
  input logic up_key,
  input logic down_key,
  input logic servo_energized_state,
  input logic operation_mode,
  input logic jog_fwd,
  input logic jog_rev,
  input logic [2:0] panel_state
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_word_pad: assert property (hrdata[31:24] == 8'h00)
    else $error("hrdata top byte set");
  a_state_legal: assert property (panel_state <= 3'h6)
    else $error("bad state");
  a_jog_exclusive: assert property (!(jog_fwd && jog_rev))
    else $error("both jog dirs");
  a_rev_cause: assert property (jog_rev |-> $past(up_key) &&
    !$past(down_key) && $past(servo_energized_state))
    else $error("reverse jog without up");
  a_fwd_cause: assert property (jog_fwd |-> $past(down_key) &&
    !$past(up_key) && $past(servo_energized_state))
    else $error("forward jog without down");
  a_servo_in_op: assert property (
    servo_energized_state |-> operation_mode)
    else $error("servo on outside op mode");
  a_servo_press: assert property ($rose(servo_energized_state) |->
    $past(jog_servo_toggle_key) && !$past(jog_servo_toggle_key, 2))
    else $error("servo on without jog press");
  a_op_press: assert property ($rose(operation_mode) |->
    $past(display_mode_key, 2) && !$past(display_mode_key, 3))
    else $error("op mode without display press");
endmodule : spm_panel_checker

// File: tb/spm_keypad.sv
// Operator keypad model pressing and holding panel keys
module spm_keypad (
  input logic mclk,
  output logic display_mode_key,
  output logic jog_servo_toggle_key,
  output logic data_enter_key,
  output logic up_key,
  output logic down_key
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] key_q = 5'h00;
  assign {down_key, up_key, data_enter_key, jog_servo_toggle_key,
    display_mode_key} = key_q;
  // Clean press, then idle so the panel settles
  task press(input int k);
    @(posedge mclk);
    key_q[k] <= 1'b1;
    repeat (2) @(posedge mclk);
    key_q[k] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : press
  task hold(input int k, input logic v);
    @(posedge mclk);
    key_q[k] <= v;
  endtask : hold
endmodule : spm_keypad

// File: tb/test_servo_panel_mode_and_status_monitor.sv
// Self-checking bench for the servo panel sequencer
module test_servo_panel_mode_and_status_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  import spm_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, st;
  logic [1:0] htrans;
  logic [2:0] hsize, panel_state;
  logic display_mode_key, jog_servo_toggle_key, data_enter_key;
  logic up_key, down_key, servo_alarm_flag, dynamic_brake_active;
  logic current_limit_active, positioning_complete, mode_switch_active;
  logic forward_current_limit, reverse_current_limit, motor_energized;
  logic encoder_phase_a_level, encoder_quadrature_b_level;
  logic encoder_index_level, hall_u_level, hall_v_level, hall_w_level;
  logic incremental_encoder, ext_servo_on, proportional_control_input;
  logic forward_travel_inhibit, reverse_travel_inhibit, alarm_event;
  logic servo_energized_state, servo_command, operation_mode;
  logic jog_fwd, jog_rev;
  logic [15:0] feedback_speed, torque_ref, pulse_count, elec_angle;
  logic [15:0] position_error, jog_speed;
  logic [7:0] motor_type, motor_mod_index, alarm_code;
  logic [23:0] display_value;
  logic [7:0] zero_ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h20};
  logic [18:0] pat [4] = '{19'h7_FFFF, 19'h0_0000, 19'h2_AAAA, 19'h1_5555};
  logic [7:0] fn_code [3] = '{SPM_FN_CLR_HIST, SPM_FN_MOTOR_PRM,
    SPM_FN_VERSION};
  logic [31:0] fn_state [3] = '{32'h1, 32'h2, 32'h2};
  logic [31:0] fn_disp [3] = '{32'h02, 32'h3C07, 32'h0000_0001};
  int miscompares = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  spm_panel DUT (.*);
  spm_keypad kp (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Bounded so a stuck slave cannot hang
  task phase;
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        complete_run();
      end
      @(posedge mclk);
    end
  endtask : phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    phase();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    phase();
    rd = hrdata;
  endtask : bus
  task core(input logic [18:0] v);
    {reverse_travel_inhibit, forward_travel_inhibit,
      proportional_control_input, ext_servo_on, incremental_encoder,
      hall_w_level, hall_v_level, hall_u_level, encoder_index_level,
      encoder_quadrature_b_level, encoder_phase_a_level, motor_energized,
      reverse_current_limit, forward_current_limit, mode_switch_active,
      positioning_complete, current_limit_active, dynamic_brake_active,
      servo_alarm_flag} <= v;
  endtask : core
  function automatic logic [31:0] stat(input logic [18:0] v);
    logic [31:0] e;
    e = '0;
    e[1] = v[0];
    e[2] = v[1];
    e[9:4] = v[7:2];
    e[12:10] = ~v[10:8];
    e[15:13] = v[14] ? ~v[13:11] : 3'h0;
    e[19:17] = v[18:16];
    return e;
  endfunction : stat
  task sel_fn(input logic [7:0] c);
    bus(1'b1, SPM_OFS_FUNC_SEL, {24'h00_0000, c});
    kp.press(2);
    kp.press(0);
  endtask : sel_fn
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {hsel, hwrite, htrans, alarm_event, reset_n, haddr, hwdata} = '0;
    hsize = 3'h2;
    {alarm_code, motor_type, motor_mod_index, feedback_speed} = '0;
    {torque_ref, pulse_count, elec_angle, position_error} = '0;
    core(19'h0_0000);
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (zero_ofs[i]) begin
      bus(1'b0, zero_ofs[i], 32'h0000_0000);
      check("reset value", 32'h0000_0000, rd);
    end
    bus(1'b1, SPM_OFS_JOG_SPEED, 32'h0000_1234);
    bus(1'b0, SPM_OFS_JOG_SPEED, 32'h0000_0000);
    check("jog speed reg", 32'h0000_1234, rd);
    @(posedge mclk);
    alarm_event <= 1'b1;
    alarm_code <= 8'h5A;
    @(posedge mclk);
    alarm_event <= 1'b0;
    bus(1'b0, SPM_OFS_HIST_DATA, 32'h0000_0000);
    check("history entry", 32'h0000_005A, rd);
    $display("Test registers done");
    bus(1'b1, SPM_OFS_INPUT_MASK, 32'h0000_0001);
    foreach (pat[i]) begin
      core(pat[i]);
      bus(1'b0, SPM_OFS_STATUS, 32'h0000_0000);
      st = stat(pat[i]);
      check("status", st, rd);
      check("servo command", 32'h0, 32'(servo_command));
    end
    $display("Test status word done");
    {feedback_speed, torque_ref} <= 32'h0101_0202;
    {pulse_count, elec_angle, position_error} <= 48'h0303_0404_0606;
    kp.press(0);
    check("monitor select", 32'h3, 32'(panel_state));
    kp.press(2);
    for (int i = 0; i < 6; i++) begin
      rd = (i == 4) ? st : 32'(i + 1) * 32'h0000_0101;
      check("monitor value", rd, 32'(display_value));
      kp.press(2);
      kp.press(3);
      kp.press(2);
    end
    kp.press(0);
    check("traceback", 32'h5, 32'(panel_state));
    kp.press(0);
    check("status display", st, 32'(display_value));
    kp.press(0);
    check("back to select", 32'h0, 32'(panel_state));
    $display("Test monitor done");
    core(19'h0_0000);
    bus(1'b1, SPM_OFS_INPUT_MASK, 32'h0000_0003);
    sel_fn(SPM_FN_JOG);
    check("op mode on", 32'h1, 32'(operation_mode));
    kp.press(1);
    check("servo on", 32'h1, 32'(servo_energized_state));
    for (int k = 3; k < 5; k++) begin
      kp.hold(k, 1'b1);
      repeat (3) @(posedge mclk);
      check("jog dir", 32'(k - 2), 32'({jog_fwd, jog_rev}));
      check("jog speed", 32'h0000_1234, 32'(jog_speed));
      kp.hold(k, 1'b0);
      repeat (3) @(posedge mclk);
      check("jog stop", 32'h0, 32'({jog_fwd, jog_rev}));
    end
    kp.press(1);
    check("servo off", 32'h0, 32'(servo_energized_state));
    kp.press(1);
    kp.press(0);
    check("op mode off", 32'h0, 32'(operation_mode));
    check("servo dropped", 32'h0, 32'(servo_energized_state));
    kp.press(2);
    check("number select", 32'h0, 32'(panel_state));
    $display("Test jog done");
    {motor_type, motor_mod_index} <= 16'h3C07;
    foreach (fn_code[i]) begin
      sel_fn(fn_code[i]);
      check("fn state", fn_state[i], 32'(panel_state));
      check("fn display", fn_disp[i], 32'(display_value));
      kp.press(2);
    end
    bus(1'b0, SPM_OFS_HIST_DATA, 32'h0000_0000);
    check("history cleared", 32'h0000_0000, rd);
    $display("Test functions done");
    complete_run();
  end
endmodule : test_servo_panel_mode_and_status_monitor

bind spm_panel spm_panel_checker u_chk (.*);
